// *** eeprom_cmd_pkg.sv ***
// Package for the serial EEPROM command, status and protection block.
// Assumes a single 200 MHz system clock; serial pins sampled by it.
`default_nettype none
package eeprom_cmd_pkg;
   // ------------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_ARM = 8'h06;
   localparam logic [7:0] OP_DISARM = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_ARR_RD = 8'h03;
   localparam logic [7:0] OP_ARR_WR = 8'h02;
   localparam logic [7:0] OP_ID_RD = 8'h83;
   localparam logic [7:0] OP_ID_WR = 8'h82;
   // ------------------------------------------------------------------
   // Status field positions and reset values
   // ------------------------------------------------------------------
   localparam int BIT_BUSY = 0;
   localparam int BIT_ARM = 1;
   localparam int BIT_GLO = 2;
   localparam int BIT_GHI = 3;
   localparam int BIT_LOCK = 7;
   localparam logic [2:0] NV_RESET = 3'h0;
   localparam int ADDR_BITS = 16;
   localparam int A10_POS = 10;
   localparam logic [1:0] GUARD_QTR = 2'h1;
   localparam logic [1:0] GUARD_HALF = 2'h2;
   localparam logic [1:0] GUARD_ALL = 2'h3;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int CYCLE_TIME_NV_US = 5000;
   localparam int CYCLE_TIME_NV_CYC = CYCLE_TIME_NV_US * CLK_MHZ;
   // Decoder states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC = 3'b001,
      ST_WAIT = 3'b010,
      ST_STREAM = 3'b011,
      ST_DATA = 3'b100,
      ST_ADDR = 3'b101,
      ST_IGNORE = 3'b110
   } dec_state_e;
   // Non-volatile status fields
   typedef struct packed {
      logic lock;
      logic ghi;
      logic glo;
   } nv_bits_s;
endpackage : eeprom_cmd_pkg
`default_nettype wire

// *** pin_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // ------------------------------------------------------------------
   // Sampling chain
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // Level changes once stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         level <= 1'b1;
      end else if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
endmodule : pin_sync
`default_nettype wire

// *** eeprom_cmd_core.sv ***
// Opcode decoder, status register and write protection of a serial EEPROM.
// Assumes serial pins asynchronous to clk; array data path lies outside.
//
// Summary of operation
// - First byte after select fall is opcode
// - Unknown opcode: ignore bus until reselect
// - Arm opcode sets arm latch at deselect
// - Disarm opcode clears arm latch at deselect
// - Arm latch clears: reset, disarm, writes done
// - Status read streams register while selected
// - Busy flag high during any write cycle
// - Arm latch low rejects array, status writes
// - Guard bits nonzero block array region writes
// - Lock bit with guard pin low: locked
// - Status write: armed, opcode plus one byte
// - Deselect right after eighth data bit
// - Status write runs timed, busy, then disarms
// - New status bits apply after cycle ends
// - Bits six, five, four read zero
// - Lock bit low: writable whatever guard pin
// - Locked mode entered in either order
// - Locked mode leaves only when pin high
// - Locked mode keeps guarded regions protected
// - Array read and write opcodes decoded
// - Ident read decoded whatever A10
// - Ident write or ident freeze by A10
// - Guard codes map to upper quarter, half, all
// - Sample on rising, shift on falling edge
`timescale 1ns/1ps
`default_nettype none
module eeprom_cmd_core #(
   parameter int CYCLE_TIME_NV_CYC = eeprom_cmd_pkg::CYCLE_TIME_NV_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial pins
   input wire logic pick_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // Protect pin
   input wire logic guard_pin,
   // Array path handshake
   output logic arr_read_go,
   output logic arr_write_go,
   output logic id_read_go,
   output logic id_write_go,
   output logic id_freeze_go,
   output logic [15:0] arr_addr,
   input wire logic arr_write_done,
   // Status view
   output logic locked_guard_mode,
   output logic [7:0] status_protect_register
);
   logic pick_s, sclk_s, sdi_s, guard_s;
   logic sclk_d_reg, pick_d_reg;
   logic rise, fall, sel_fall, sel_rise;
   eeprom_cmd_pkg::dec_state_e state_reg;
   logic [7:0] shift_reg;
   logic [7:0] opc_reg;
   logic [3:0] bitcnt_reg;
   logic [4:0] addr_cnt_reg;
   logic [15:0] addr_reg;
   logic [7:0] out_reg;
   logic byte_done, byte_edge_reg;
   logic arm_latch, busy_flag;
   logic sw_busy_reg, arr_busy_reg;
   logic [31:0] timer_reg;
   eeprom_cmd_pkg::nv_bits_s nv_reg, nv_pend_reg;
   logic sw_valid_reg;
   logic [1:0] guard;
   logic addr_guarded;
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   pin_sync u_pick (.clk(clk), .reset_n(reset_n), .pin(pick_n), .level(pick_s));
   pin_sync u_sclk (.clk(clk), .reset_n(reset_n), .pin(sclk), .level(sclk_s));
   pin_sync u_sdi (.clk(clk), .reset_n(reset_n), .pin(sdi), .level(sdi_s));
   pin_sync u_guard (.clk(clk), .reset_n(reset_n), .pin(guard_pin), .level(guard_s));
   // Edge detection on filtered levels
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sclk_d_reg <= 1'b0;
         pick_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         pick_d_reg <= pick_s;
      end
   end
   assign rise = sclk_s & ~sclk_d_reg & ~pick_s;
   assign fall = ~sclk_s & sclk_d_reg & ~pick_s;
   assign sel_fall = pick_d_reg & ~pick_s;
   assign sel_rise = ~pick_d_reg & pick_s;
   assign byte_done = rise && bitcnt_reg == 4'h7;
   assign busy_flag = sw_busy_reg | arr_busy_reg;
   assign guard = {nv_reg.ghi, nv_reg.glo};
   // ------------------------------------------------------------------
   // Protection
   // ------------------------------------------------------------------
   // Region decode from guard code
   always_comb begin
      unique case (guard)
         eeprom_cmd_pkg::GUARD_QTR: addr_guarded = addr_reg[15:14] == 2'h3;
         eeprom_cmd_pkg::GUARD_HALF: addr_guarded = addr_reg[15];
         eeprom_cmd_pkg::GUARD_ALL: addr_guarded = 1'b1;
         default: addr_guarded = 1'b0;
      endcase
   end
   // Locked mode follows lock bit and pin in either order
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         locked_guard_mode <= 1'b0;
      end else begin
         locked_guard_mode <= nv_reg.lock & ~guard_s;
      end
   end
   // Bit shifter, MSB first
   always_ff @(posedge clk) begin
      if (!reset_n || sel_fall) begin
         bitcnt_reg <= 4'h0;
         shift_reg <= 8'h00;
      end else if (rise) begin
         shift_reg <= {shift_reg[6:0], sdi_s};
         bitcnt_reg <= (bitcnt_reg == 4'h7) ? 4'h0 : bitcnt_reg + 4'h1;
      end
   end
   // Marks that the last rising edge closed a byte
   always_ff @(posedge clk) begin
      if (!reset_n || sel_fall) begin
         byte_edge_reg <= 1'b0;
      end else if (rise) begin
         byte_edge_reg <= byte_done;
      end
   end
   // ------------------------------------------------------------------
   // Decoder state machine
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= eeprom_cmd_pkg::ST_IGNORE;
         opc_reg <= 8'h00;
         addr_cnt_reg <= 5'h0;
      end else if (sel_fall) begin
         state_reg <= eeprom_cmd_pkg::ST_OPC;
      end else if (pick_s) begin
         state_reg <= eeprom_cmd_pkg::ST_IDLE;
      end else if (byte_done) begin
         unique case (state_reg)
            eeprom_cmd_pkg::ST_OPC: begin
               opc_reg <= {shift_reg[6:0], sdi_s};
               addr_cnt_reg <= 5'h0;
               unique case ({shift_reg[6:0], sdi_s})
                  eeprom_cmd_pkg::OP_ARM, eeprom_cmd_pkg::OP_DISARM:
                     state_reg <= eeprom_cmd_pkg::ST_WAIT;
                  eeprom_cmd_pkg::OP_STAT_RD: state_reg <= eeprom_cmd_pkg::ST_STREAM;
                  eeprom_cmd_pkg::OP_STAT_WR: state_reg <= eeprom_cmd_pkg::ST_DATA;
                  eeprom_cmd_pkg::OP_ARR_RD, eeprom_cmd_pkg::OP_ARR_WR,
                  eeprom_cmd_pkg::OP_ID_RD, eeprom_cmd_pkg::OP_ID_WR:
                     state_reg <= eeprom_cmd_pkg::ST_ADDR;
                  default: state_reg <= eeprom_cmd_pkg::ST_IGNORE;
               endcase
            end
            eeprom_cmd_pkg::ST_ADDR: begin
               addr_cnt_reg <= addr_cnt_reg + 5'h1;
               if (addr_cnt_reg == 5'h1) begin
                  state_reg <= eeprom_cmd_pkg::ST_STREAM;
               end
            end
            default: state_reg <= state_reg;
         endcase
      end
   end
   // Address capture
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr_reg <= 16'h0000;
      end else if (byte_done && state_reg == eeprom_cmd_pkg::ST_ADDR) begin
         addr_reg <= {addr_reg[7:0], shift_reg[6:0], sdi_s};
      end
   end
   // Array path read starts
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arr_read_go <= 1'b0;
         id_read_go <= 1'b0;
         arr_addr <= 16'h0000;
      end else begin
         arr_read_go <= 1'b0;
         id_read_go <= 1'b0;
         if (byte_done && state_reg == eeprom_cmd_pkg::ST_ADDR && addr_cnt_reg == 5'h1
             && !busy_flag) begin
            arr_addr <= {addr_reg[7:0], shift_reg[6:0], sdi_s};
            arr_read_go <= opc_reg == eeprom_cmd_pkg::OP_ARR_RD;
            id_read_go <= opc_reg == eeprom_cmd_pkg::OP_ID_RD;
         end
      end
   end
   // Write starts at deselect on a byte boundary
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arr_write_go <= 1'b0;
         id_write_go <= 1'b0;
         id_freeze_go <= 1'b0;
      end else begin
         arr_write_go <= 1'b0;
         id_write_go <= 1'b0;
         id_freeze_go <= 1'b0;
         if (sel_rise && state_reg == eeprom_cmd_pkg::ST_STREAM && byte_edge_reg
             && bitcnt_reg == 4'h0 && arm_latch && !busy_flag) begin
            arr_write_go <= opc_reg == eeprom_cmd_pkg::OP_ARR_WR && !addr_guarded;
            id_write_go <= opc_reg == eeprom_cmd_pkg::OP_ID_WR && !addr_reg[eeprom_cmd_pkg::A10_POS]
                           && guard != eeprom_cmd_pkg::GUARD_ALL;
            id_freeze_go <= opc_reg == eeprom_cmd_pkg::OP_ID_WR
                            && addr_reg[eeprom_cmd_pkg::A10_POS];
         end
      end
   end
   // Status write capture and self-timed cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         nv_pend_reg <= eeprom_cmd_pkg::NV_RESET;
         sw_valid_reg <= 1'b0;
      end else if (sel_fall) begin
         sw_valid_reg <= 1'b0;
      end else if (rise) begin
         sw_valid_reg <= byte_done && state_reg == eeprom_cmd_pkg::ST_DATA;
         if (byte_done && state_reg == eeprom_cmd_pkg::ST_DATA) begin
            nv_pend_reg <= {shift_reg[6], shift_reg[2], shift_reg[1]};
         end
      end
   end
   // Cycle timer, busy and commit
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sw_busy_reg <= 1'b0;
         timer_reg <= 32'h0;
         nv_reg <= eeprom_cmd_pkg::NV_RESET;
      end else if (sw_busy_reg) begin
         if (timer_reg == 32'(CYCLE_TIME_NV_CYC - 1)) begin
            sw_busy_reg <= 1'b0;
            nv_reg <= nv_pend_reg;
         end
         timer_reg <= timer_reg + 32'h1;
      end else if (sel_rise && sw_valid_reg && arm_latch && !busy_flag
                   && !locked_guard_mode) begin
         sw_busy_reg <= 1'b1;
         timer_reg <= 32'h0;
      end
   end
   // Array write busy tracked until the array path reports done
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arr_busy_reg <= 1'b0;
      end else if (arr_write_go || id_write_go || id_freeze_go) begin
         arr_busy_reg <= 1'b1;
      end else if (arr_write_done) begin
         arr_busy_reg <= 1'b0;
      end
   end
   // Arm latch
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arm_latch <= 1'b0;
      end else if (sel_rise && state_reg == eeprom_cmd_pkg::ST_WAIT && bitcnt_reg == 4'h0) begin
         arm_latch <= opc_reg == eeprom_cmd_pkg::OP_ARM;
      end else if ((sw_busy_reg && timer_reg == 32'(CYCLE_TIME_NV_CYC - 1))
                   || (arr_busy_reg && arr_write_done)) begin
         arm_latch <= 1'b0;
      end
   end
   // Status view and serial output
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status_protect_register <= 8'h00;
      end else begin
         status_protect_register <= {nv_reg.lock, 3'h0, nv_reg.ghi, nv_reg.glo,
                                     arm_latch, busy_flag};
      end
   end
   // Output shifter reloads each byte while status read runs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         out_reg <= 8'h00;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else if (state_reg != eeprom_cmd_pkg::ST_STREAM
                   || opc_reg != eeprom_cmd_pkg::OP_STAT_RD || pick_s) begin
         sdo_oe <= 1'b0;
         out_reg <= status_protect_register;
      end else if (fall) begin
         sdo_oe <= 1'b1;
         if (bitcnt_reg == 4'h0) begin
            sdo <= status_protect_register[7];
            out_reg <= {status_protect_register[6:0], 1'b0};
         end else begin
            sdo <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_lock_mode;
      @(posedge clk) disable iff (!reset_n) (nv_reg.lock && !guard_s) |=> locked_guard_mode;
   endproperty
   a_lock_mode: assert property (p_lock_mode) else $error("locked mode missed");
   property p_unlock;
      @(posedge clk) disable iff (!reset_n) guard_s |=> !locked_guard_mode;
   endproperty
   a_unlock: assert property (p_unlock) else $error("locked mode kept");
   property p_zero_bits;
      @(posedge clk) disable iff (!reset_n) status_protect_register[6:4] == 3'h0;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("reserved bit set");
   property p_nv_hold;
      @(posedge clk) disable iff (!reset_n) !sw_busy_reg |=> $stable(nv_reg);
   endproperty
   a_nv_hold: assert property (p_nv_hold) else $error("status bits changed early");
   property p_no_unarmed_sw;
      @(posedge clk) disable iff (!reset_n) $rose(sw_busy_reg) |-> $past(arm_latch);
   endproperty
   a_no_unarmed_sw: assert property (p_no_unarmed_sw) else $error("unarmed write");
   property p_busy_view;
      @(posedge clk) disable iff (!reset_n) sw_busy_reg |=> status_protect_register[0];
   endproperty
   a_busy_view: assert property (p_busy_view) else $error("busy not shown");
   property p_arm_clear;
      @(posedge clk) disable iff (!reset_n) $fell(sw_busy_reg) |-> !arm_latch;
   endproperty
   a_arm_clear: assert property (p_arm_clear) else $error("arm stayed set");
   property p_guard_all;
      @(posedge clk) disable iff (!reset_n) guard == 2'h3 |=> !arr_write_go;
   endproperty
   a_guard_all: assert property (p_guard_all) else $error("guarded write");
endmodule : eeprom_cmd_core
`default_nettype wire

// *** spi_host_model.sv ***
// SPI bus master model that drives the select, clock and data pins.
// Assumes mode 0 (clock idles low) and a link clock of 160 ns.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Serial pins toward the device
   output logic pick_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   localparam int HALF_NS = 80;
   // --------------------------------------------------------------
   // Idle bus
   // --------------------------------------------------------------
   initial begin
      pick_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Open a frame; every instruction starts here
   task automatic sel();
      pick_n = 1'b0;
      #(HALF_NS);
   endtask : sel
   // Shift n bits out MSB first, take reply bits on rising edges
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sdi = tx[i];
         #(HALF_NS);
         sclk = 1'b1;
         rx = {rx[6:0], sdo};
         #(HALF_NS);
         sclk = 1'b0;
      end
   endtask : xfer
   // Close frame before the next rising edge; data line no longer valid
   task automatic desel();
      #(HALF_NS / 2);
      pick_n = 1'b1;
      sdi = ~sdi;
      #(4 * HALF_NS);
   endtask : desel
endmodule : spi_host_model
`default_nettype wire

// *** spi_eeprom_cmd_status_protect_test.sv ***
// Testbench for the EEPROM command, status and protection core.
// Assumes the SPI master model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_cmd_status_protect_test;
   logic clk = 1'b0, reset_n = 1'b0, guard_pin = 1'b1, arr_write_done = 1'b0;
   logic pick_n, sclk, sdi, sdo, arr_write_go, arr_read_go, locked_guard_mode;
   logic sdo_oe, id_read_go;
   int n_irgo = 0;
   logic [15:0] arr_addr;
   logic [7:0] status_protect_register, d, v;
   int fail_count = 0, n_compared = 0, n_wgo = 0, n_rgo = 0;
   // --------------------------------------------------------------
   // Clock, device and bus master
   // --------------------------------------------------------------
   always #2.5 clk = ~clk;
   eeprom_cmd_core #(.CYCLE_TIME_NV_CYC(2000)) i_dut (.clk(clk), .reset_n(reset_n),
      .pick_n(pick_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .guard_pin(guard_pin), .arr_read_go(arr_read_go), .arr_write_go(arr_write_go),
      .id_read_go(id_read_go), .id_write_go(), .id_freeze_go(), .arr_addr(arr_addr),
      .arr_write_done(arr_write_done), .locked_guard_mode(locked_guard_mode),
      .status_protect_register(status_protect_register));
   spi_host_model i_host (.pick_n(pick_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
   // Count launch pulses toward the array path
   always @(posedge clk) begin
      n_wgo <= n_wgo + (arr_write_go === 1'b1);
      n_rgo <= n_rgo + (arr_read_go === 1'b1);
      n_irgo <= n_irgo + (id_read_go === 1'b1);
   end
   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic end_sim();
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic cmd(input logic [7:0] op);
      i_host.sel();
      i_host.xfer(op, 8, d);
      i_host.desel();
   endtask : cmd
   // Status read: opcode, then one status byte
   task automatic rd(input logic [7:0] exp);
      i_host.sel();
      i_host.xfer(8'h05, 8, d);
      i_host.xfer(8'h00, 8, v);
      i_host.desel();
      chk(v, exp);
   endtask : rd
   task automatic wr_status(input logic [7:0] val, input int n);
      i_host.sel();
      i_host.xfer(8'h01, 8, d);
      i_host.xfer(val, n, d);
      i_host.desel();
   endtask : wr_status
   task automatic arr_wr(input logic [15:0] a);
      i_host.sel();
      i_host.xfer(8'h02, 8, d);
      i_host.xfer(a[15:8], 8, d);
      i_host.xfer(a[7:0], 8, d);
      i_host.xfer(8'h5a, 8, d);
      i_host.desel();
   endtask : arr_wr
   // Bounded wait for the busy flag to drop
   task automatic wait_idle();
      int k;
      for (k = 0; k < 5000 && status_protect_register[0] !== 1'b0; k++) cyc(1);
      if (k == 5000) begin
         fail_count++;
         end_sim();
      end
   endtask : wait_idle
   task automatic set_pin(input logic lvl);
      @(posedge clk);
      #1 guard_pin = lvl;
      cyc(20);
   endtask : set_pin
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   initial begin
      cyc(8);
      reset_n = 1'b1;
      cyc(4);
      rd(8'h00);
      cmd(8'h06);
      i_host.sel();
      i_host.xfer(8'h05, 8, d);
      i_host.xfer(8'h00, 8, v);
      chk(v, 8'h02);
      i_host.xfer(8'h00, 8, v);
      i_host.desel();
      chk(v, 8'h02);
      cmd(8'h04);
      rd(8'h00);
      wr_status(8'hff, 8);
      arr_wr(16'h0000);
      rd(8'h00);
      chk(n_wgo, 0);
      cmd(8'h06);
      wr_status(8'hff, 7);
      rd(8'h02);
      wr_status(8'hff, 8);
      chk(status_protect_register, 8'h03);
      rd(8'h03);
      wait_idle();
      rd(8'h8c);
      chk(locked_guard_mode, 1'b0);
      cmd(8'h06);
      arr_wr(16'h0000);
      chk(n_wgo, 0);
      set_pin(1'b0);
      chk(locked_guard_mode, 1'b1);
      wr_status(8'h00, 8);
      cyc(50);
      rd(8'h8e);
      set_pin(1'b1);
      chk(locked_guard_mode, 1'b0);
      wr_status(8'h04, 8);
      wait_idle();
      rd(8'h04);
      set_pin(1'b0);
      chk(locked_guard_mode, 1'b0);
      cmd(8'h06);
      wr_status(8'h84, 8);
      wait_idle();
      rd(8'h84);
      chk(locked_guard_mode, 1'b1);
      cmd(8'h06);
      arr_wr(16'h8000);
      chk(n_wgo, 1);
      chk(status_protect_register[0], 1'b1);
      @(posedge clk);
      #1 arr_write_done = 1'b1;
      cyc(1);
      arr_write_done = 1'b0;
      wait_idle();
      rd(8'h84);
      cmd(8'h06);
      arr_wr(16'hc000);
      chk(n_wgo, 1);
      i_host.sel();
      i_host.xfer(8'ha5, 8, d);
      i_host.xfer(8'h04, 8, d);
      i_host.desel();
      rd(8'h86);
      i_host.sel();
      i_host.xfer(8'h03, 8, d);
      i_host.xfer(8'h12, 8, d);
      i_host.xfer(8'h34, 8, d);
      i_host.desel();
      chk(n_rgo, 1);
      chk(arr_addr, 16'h1234);
      chk(sdo_oe, 1'b0);
      i_host.sel();
      i_host.xfer(8'h83, 8, d);
      i_host.xfer(8'h00, 8, d);
      i_host.xfer(8'h12, 8, d);
      i_host.desel();
      chk(n_irgo, 1);
      chk(arr_addr, 16'h0012);
      end_sim();
   end
endmodule : spi_eeprom_cmd_status_protect_test
`default_nettype wire
